//--- rfcs_defs.vh
// Register map, field positions and reset values of the RF frontend control/status bank
`ifndef RFCS_DEFS_VH
`define RFCS_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RFCS_ADDR_W 16
`define RFCS_OFF_TXCLK 16'h0021
`define RFCS_OFF_RXCTL 16'h0022
`define RFCS_OFF_FDCTL 16'h0023
`define RFCS_OFF_STAT 16'h0024

// ----------------------------------------
// Writable masks and reset values
// ----------------------------------------
`define RFCS_TXCLK_MASK 32'h0004_3FFF
`define RFCS_RXCTL_MASK 32'h0000_00FF
`define RFCS_FDCTL_MASK 32'h0000_7FFF
`define RFCS_TXCLK_RST 32'h0000_0000
`define RFCS_RXCTL_RST 32'h0000_0000
`define RFCS_FDCTL_RST 32'h0000_0000

// ----------------------------------------
// Transmit clock control fields
// ----------------------------------------
`define RFCS_TX_LM_EN_BIT 18
`define RFCS_TX_PHASE_LSB 11
`define RFCS_TX_OVMODE_LSB 8
`define RFCS_TX_D2INV_R_BIT 7
`define RFCS_TX_D2INV_C_BIT 6
`define RFCS_TX_D1INV_R_BIT 5
`define RFCS_TX_D1INV_C_BIT 4
`define RFCS_TX_RDMODE_LSB 1
`define RFCS_TX_DPLL_BIT 0

// ----------------------------------------
// Receiver control fields
// ----------------------------------------
`define RFCS_RX_MILLER_LSB 6
`define RFCS_RX_MIXER_LSB 4
`define RFCS_HIGHPASS_CORNER_SELECT_LSB 2
`define RFCS_RX_GAIN_LSB 0
`define RFCS_MIX_READER 2'h1
`define RFCS_MIX_CARD 2'h2

// ----------------------------------------
// Field detector control fields
// ----------------------------------------
`define RFCS_FD_PD_BIT 14
`define RFCS_FD_SRC_LSB 12
`define RFCS_FD_NFLVL_LSB 8
`define RFCS_FD_UREF_LSB 4
`define RFCS_FD_LREF_LSB 0
`define RFCS_SRC_NEAR 2'h0
`define RFCS_SRC_LEVEL 2'h1
`define RFCS_SRC_BOTH 2'h2
`define RFCS_SRC_FORCE 2'h3

// ----------------------------------------
// Status fields
// ----------------------------------------
`define RFCS_ST_PARAM_BIT 8
`define RFCS_ST_SYNTAX_BIT 7
`define RFCS_ST_SEMANT_BIT 6
`define RFCS_ST_STBY_BIT 5

`endif

//--- rfcs_host_model.sv
// Host controller model driving the register strobe port
`timescale 1ns/1ps
module rfcs_host_model
(
    input wire clk_sys_i, // clock
    output reg [15:0] addr_o, // address
    output reg [31:0] wdata_o, // data
    output reg wr_o, // write
    output reg rd_o // read
);
    initial
    begin
        addr_o = 16'h0000;
        wdata_o = 32'h0000_0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // Released lines flip so stale values never pass
    task wr(input logic [15:0] a, input logic [31:0] d);
    begin
        @(posedge clk_sys_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_sys_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    end
    endtask
    task rd(input logic [15:0] a);
    begin
        @(posedge clk_sys_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_sys_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
    end
    endtask
endmodule // rfcs_host_model

//--- rfcs_pin_sync.v
// Three-stage synchroniser with agreement filter for asynchronous pin levels
`timescale 1ns/1ps

module rfcs_pin_sync
#(
    parameter W = 2
)
(
    input wire clk_sys_i, // System clock
    input wire rst_i, // Synchronous reset, active high
    input wire [W-1:0] pin_i, // Asynchronous levels
    output reg [W-1:0] level_o // Filtered levels
);

reg [W-1:0] s1_r;
reg [W-1:0] s2_r;
reg [W-1:0] s3_r;

// ----------------------------------------
// Sync chain; stage one feeds stage two only
// ----------------------------------------
always @(posedge clk_sys_i)
begin
    if (rst_i)
    begin
        s1_r <= {W{1'b0}};
        s2_r <= {W{1'b0}};
        s3_r <= {W{1'b0}};
        level_o <= {W{1'b0}};
    end
    else
    begin
        s1_r <= pin_i;
        s2_r <= s1_r;
        s3_r <= s2_r;
        // Per bit: change accepted once stages two and three agree
        level_o <= (s2_r & s3_r) | (level_o & (s2_r | s3_r));
    end
end

endmodule // rfcs_pin_sync

//--- rfcs_regs.v
// RF frontend control and status register bank with decoded analog controls
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "rfcs_defs.vh"

module rfcs_regs
(
    input wire clk_sys_i, // System clock, 25 MHz
    input wire rst_i, // Synchronous reset, active high
    input wire [15:0] addr_i, // Register address
    input wire [31:0] wdata_i, // Write data
    input wire wr_i, // Write strobe
    input wire rd_i, // Read strobe
    output reg [31:0] rdata_o, // Read data, cycle after strobe
    input wire param_err_i, // Host link parameter error pulse
    input wire syntax_err_i, // Host link syntax error pulse
    input wire semantic_err_i, // Host link semantic error pulse
    input wire err_clear_i, // Clear host link error flags
    input wire standby_req_i, // Standby entry request pulse
    input wire nearfield_det_i, // Near-field detector pin, async
    input wire level_det_i, // RF level detector pin, async
    input wire overshoot_guard_i, // Overshoot/undershoot guard active
    input wire card_mode_i, // 1 card mode, 0 reader mode
    output reg card_load_mod_enable_o, // Active load modulation in use
    output reg [2:0] load_mod_clock_phase_o, // Phase in 45-degree steps
    output reg [2:0] tx_clock_mode_o, // Transmit clock mode in effect
    output reg driver1_invert_o, // Driver 1 uses inverted carrier
    output reg driver2_invert_o, // Driver 2 uses inverted carrier
    output reg digital_pll_enable_o, // Digital PLL enable
    output reg [1:0] miller_demod_reference_o, // Miller reference level
    output reg reader_mixer_en_o, // Reader mode mixer powered
    output reg card_mixer_en_o, // Card mode mixer powered
    output reg [3:0] highpass_corner_onehot_o, // 45/85/150/250 kHz
    output reg [3:0] baseband_gain_onehot_o, // 33/40/50/57 dB
    output reg nearfield_detector_powerdown_o, // Near-field detector off
    output reg [3:0] nearfield_detect_level_o, // Near-field level
    output reg [3:0] level_detector_upper_ref_o, // Level detector upper ref
    output reg [3:0] level_detector_lower_ref_o, // Level detector lower ref
    output reg field_present_o, // RF field present indication
    output reg standby_grant_o // Standby entry granted pulse
);

// ----------------------------------------
// Helpers
// ----------------------------------------
function [3:0] rfcs_onehot4;
    input [1:0] sel;
    begin
        rfcs_onehot4 = 4'h1 << sel;
    end
endfunction

function [1:0] rfcs_fld2;
    input [31:0] word;
    input integer lsb;
    begin
        rfcs_fld2 = word[lsb +: 2];
    end
endfunction

// ----------------------------------------
// Storage
// ----------------------------------------
reg [31:0] txclk_r;
reg [31:0] rxctl_r;
reg [31:0] fdctl_r;
reg param_err_r;
reg syntax_err_r;
reg semantic_err_r;
reg stby_block_r;
reg [31:0] rdata_nxt;
reg field_nxt;
reg [1:0] mix_sel;
reg [1:0] src_sel;
reg [31:0] txclk_nxt;
reg [31:0] rxctl_nxt;
reg [31:0] fdctl_nxt;
reg [2:0] tx_mode_nxt;
reg drv1_inv_nxt;
reg drv2_inv_nxt;
wire [1:0] det_sync;
wire near_sync;
wire level_sync;

// ----------------------------------------
// Detector pin synchronisers
// ----------------------------------------
rfcs_pin_sync #(.W(2)) u_det_sync
(
    .clk_sys_i (clk_sys_i),
    .rst_i (rst_i),
    .pin_i ({level_det_i, nearfield_det_i}),
    .level_o (det_sync)
);

// Powered-down detector cannot indicate a field
assign near_sync = det_sync[0] & ~fdctl_r[`RFCS_FD_PD_BIT];
assign level_sync = det_sync[1];

// ----------------------------------------
// Register write decode
// ----------------------------------------
// Masking on the way in keeps reserved bits zero, so reads need no mask
always @*
begin
    txclk_nxt = txclk_r;
    rxctl_nxt = rxctl_r;
    fdctl_nxt = fdctl_r;
    if (wr_i)
    begin
        case (addr_i)
            `RFCS_OFF_TXCLK: txclk_nxt = wdata_i & `RFCS_TXCLK_MASK;
            `RFCS_OFF_RXCTL: rxctl_nxt = wdata_i & `RFCS_RXCTL_MASK;
            `RFCS_OFF_FDCTL: fdctl_nxt = wdata_i & `RFCS_FDCTL_MASK;
            // Status word is read-only; its writes land here
            default:
            begin
            end
        endcase
    end
end

// ----------------------------------------
// Register storage
// ----------------------------------------
always @(posedge clk_sys_i)
begin
    if (rst_i)
    begin
        txclk_r <= `RFCS_TXCLK_RST;
        rxctl_r <= `RFCS_RXCTL_RST;
        fdctl_r <= `RFCS_FDCTL_RST;
    end
    else
    begin
        txclk_r <= txclk_nxt;
        rxctl_r <= rxctl_nxt;
        fdctl_r <= fdctl_nxt;
    end
end

// ----------------------------------------
// Host link error flags: set wins over clear
// ----------------------------------------
// A clear that meets a fresh error must not lose that error
always @(posedge clk_sys_i)
begin
    if (rst_i)
    begin
        param_err_r <= 1'b0;
        syntax_err_r <= 1'b0;
        semantic_err_r <= 1'b0;
    end
    else
    begin
        param_err_r <= param_err_i | (param_err_r & ~err_clear_i);
        syntax_err_r <= syntax_err_i | (syntax_err_r & ~err_clear_i);
        semantic_err_r <= semantic_err_i | (semantic_err_r & ~err_clear_i);
    end
end

// ----------------------------------------
// Standby request arbitration
// ----------------------------------------
always @(posedge clk_sys_i)
begin
    if (rst_i)
    begin
        stby_block_r <= 1'b0;
        standby_grant_o <= 1'b0;
    end
    else
    begin
        // Each request refreshes the flag: refused sets it, granted clears it
        if (standby_req_i)
        begin
            stby_block_r <= level_sync;
        end
        standby_grant_o <= standby_req_i & ~level_sync;
    end
end

// ----------------------------------------
// Read path
// ----------------------------------------
always @*
begin
    rdata_nxt = 32'h0000_0000;
    case (addr_i)
        `RFCS_OFF_TXCLK: rdata_nxt = txclk_r;
        `RFCS_OFF_RXCTL: rdata_nxt = rxctl_r;
        `RFCS_OFF_FDCTL: rdata_nxt = fdctl_r;
        `RFCS_OFF_STAT:
        begin
            rdata_nxt[`RFCS_ST_PARAM_BIT] = param_err_r;
            rdata_nxt[`RFCS_ST_SYNTAX_BIT] = syntax_err_r;
            rdata_nxt[`RFCS_ST_SEMANT_BIT] = semantic_err_r;
            rdata_nxt[`RFCS_ST_STBY_BIT] = stby_block_r;
        end
        default: rdata_nxt = 32'h0000_0000;
    endcase
end

// Unmapped reads and idle cycles answer zero
always @(posedge clk_sys_i)
begin
    if (rst_i)
    begin
        rdata_o <= 32'h0000_0000;
    end
    else
    begin
        rdata_o <= rd_i ? rdata_nxt : 32'h0000_0000;
    end
end

// ----------------------------------------
// Field-present selection
// ----------------------------------------
always @*
begin
    src_sel = rfcs_fld2(fdctl_r, `RFCS_FD_SRC_LSB);
    case (src_sel)
        `RFCS_SRC_NEAR: field_nxt = near_sync;
        `RFCS_SRC_LEVEL: field_nxt = level_sync;
        `RFCS_SRC_BOTH: field_nxt = near_sync | level_sync;
        `RFCS_SRC_FORCE: field_nxt = 1'b1;
        default: field_nxt = 1'b0;
    endcase
end

// ----------------------------------------
// Mode-dependent selections
// ----------------------------------------
always @*
begin
    // Guard mode stands in for the normal mode only while the guard is on
    if (overshoot_guard_i)
    begin
        tx_mode_nxt = txclk_r[`RFCS_TX_OVMODE_LSB +: 3];
    end
    else
    begin
        tx_mode_nxt = txclk_r[`RFCS_TX_RDMODE_LSB +: 3];
    end
    if (card_mode_i)
    begin
        drv1_inv_nxt = txclk_r[`RFCS_TX_D1INV_C_BIT];
        drv2_inv_nxt = txclk_r[`RFCS_TX_D2INV_C_BIT];
    end
    else
    begin
        drv1_inv_nxt = txclk_r[`RFCS_TX_D1INV_R_BIT];
        drv2_inv_nxt = txclk_r[`RFCS_TX_D2INV_R_BIT];
    end
    mix_sel = rfcs_fld2(rxctl_r, `RFCS_RX_MIXER_LSB);
end

// ----------------------------------------
// Transmit clock outputs
// ----------------------------------------
always @(posedge clk_sys_i)
begin
    if (rst_i)
    begin
        card_load_mod_enable_o <= 1'b0;
        load_mod_clock_phase_o <= 3'h0;
        tx_clock_mode_o <= 3'h0;
        driver1_invert_o <= 1'b0;
        driver2_invert_o <= 1'b0;
        digital_pll_enable_o <= 1'b0;
    end
    else
    begin
        // Load modulation only makes sense while in card mode
        card_load_mod_enable_o <= txclk_r[`RFCS_TX_LM_EN_BIT] & card_mode_i;
        load_mod_clock_phase_o <= txclk_r[`RFCS_TX_PHASE_LSB +: 3];
        tx_clock_mode_o <= tx_mode_nxt;
        driver1_invert_o <= drv1_inv_nxt;
        driver2_invert_o <= drv2_inv_nxt;
        digital_pll_enable_o <= txclk_r[`RFCS_TX_DPLL_BIT];
    end
end

// ----------------------------------------
// Receiver outputs
// ----------------------------------------
always @(posedge clk_sys_i)
begin
    if (rst_i)
    begin
        miller_demod_reference_o <= 2'h0;
        reader_mixer_en_o <= 1'b0;
        card_mixer_en_o <= 1'b0;
        // Zero codes select the first corner and the first gain step
        highpass_corner_onehot_o <= 4'h1;
        baseband_gain_onehot_o <= 4'h1;
    end
    else
    begin
        miller_demod_reference_o <= rfcs_fld2(rxctl_r, `RFCS_RX_MILLER_LSB);
        // Codes 00 and 11 leave both mixers powered down
        reader_mixer_en_o <= (mix_sel == `RFCS_MIX_READER);
        card_mixer_en_o <= (mix_sel == `RFCS_MIX_CARD);
        highpass_corner_onehot_o <= rfcs_onehot4(rfcs_fld2(rxctl_r, `RFCS_HIGHPASS_CORNER_SELECT_LSB));
        baseband_gain_onehot_o <= rfcs_onehot4(rfcs_fld2(rxctl_r, `RFCS_RX_GAIN_LSB));
    end
end

// ----------------------------------------
// Field detector outputs
// ----------------------------------------
always @(posedge clk_sys_i)
begin
    if (rst_i)
    begin
        nearfield_detector_powerdown_o <= 1'b0;
        nearfield_detect_level_o <= 4'h0;
        level_detector_upper_ref_o <= 4'h0;
        level_detector_lower_ref_o <= 4'h0;
        field_present_o <= 1'b0;
    end
    else
    begin
        nearfield_detector_powerdown_o <= fdctl_r[`RFCS_FD_PD_BIT];
        nearfield_detect_level_o <= fdctl_r[`RFCS_FD_NFLVL_LSB +: 4];
        // Bits 7:4 carry the higher of the two references
        level_detector_upper_ref_o <= fdctl_r[`RFCS_FD_UREF_LSB +: 4];
        level_detector_lower_ref_o <= fdctl_r[`RFCS_FD_LREF_LSB +: 4];
        field_present_o <= field_nxt;
    end
end

endmodule // rfcs_regs

//--- rfcs_regs_assertions.sv
// Port-level assertion checker for the RF frontend register bank
`timescale 1ns/1ps
module rfcs_chk
(
    input wire clk_sys_i, // clock
    input wire rst_i, // reset
    input wire [15:0] addr_i, // address
    input wire [31:0] wdata_i, // data
    input wire wr_i, // write
    input wire rd_i, // read
    input wire [31:0] rdata_o, // read data
    input wire standby_req_i, // standby
    input wire card_mode_i, // card mode
    input wire card_load_mod_enable_o, // load mod
    input wire [2:0] load_mod_clock_phase_o, // phase
    input wire reader_mixer_en_o, // mixer
    input wire card_mixer_en_o, // mixer
    input wire [3:0] baseband_gain_onehot_o, // gain
    input wire field_present_o, // field
    input wire standby_grant_o // grant
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    wire wr_tx = wr_i && addr_i == 16'h0021;
    wire wr_rx = wr_i && addr_i == 16'h0022;
    wire wr_fd = wr_i && addr_i == 16'h0023;
    idle_read_zero_a: assert property (!rd_i |=> rdata_o == 32'h0000_0000) else $error("rdata not zero");
    status_reserved_a: assert property (rd_i && addr_i == 16'h0024
        |=> rdata_o[31:9] == 0 && rdata_o[4:0] == 0) else $error("status reserved bits set");
    phase_follow_a: assert property (wr_tx |-> ##2 load_mod_clock_phase_o == $past(wdata_i[13:11], 2))
        else $error("phase wrong");
    load_mod_card_a: assert property (card_load_mod_enable_o |-> $past(card_mode_i)) else $error("load mod in reader");
    mixer_decode_a: assert property (wr_rx |-> ##2 reader_mixer_en_o == ($past(wdata_i[5:4], 2) == 2'h1)
        && card_mixer_en_o == ($past(wdata_i[5:4], 2) == 2'h2)) else $error("mixer wrong");
    gain_decode_a: assert property (wr_rx |-> ##2 baseband_gain_onehot_o == 4'h1 << $past(wdata_i[1:0], 2))
        else $error("gain wrong");
    forced_field_a: assert property (wr_fd && wdata_i[13:12] == 2'h3 |-> ##2 field_present_o) else $error("no field");
    grant_cause_a: assert property (standby_grant_o |-> $past(standby_req_i)) else $error("grant unasked");
    cover property (wr_rx ##2 reader_mixer_en_o);
    cover property (standby_grant_o);
    cover property (rd_i && addr_i == 16'h0024);
endmodule // rfcs_chk

//--- tb_top.sv
// Testbench for the RF frontend control and status register bank
`timescale 1ns/1ps
module tb_top;
    logic clk_sys_i, rst_i, param_err_i, syntax_err_i, semantic_err_i, err_clear_i, standby_req_i;
    logic nearfield_det_i, level_det_i, overshoot_guard_i, card_mode_i, rd_q;
    wire [15:0] addr_i;
    wire [31:0] wdata_i, rdata_o;
    wire wr_i, rd_i, card_load_mod_enable_o, driver1_invert_o, driver2_invert_o, digital_pll_enable_o;
    wire reader_mixer_en_o, card_mixer_en_o, nearfield_detector_powerdown_o, field_present_o, standby_grant_o;
    wire [2:0] load_mod_clock_phase_o, tx_clock_mode_o;
    wire [1:0] miller_demod_reference_o;
    wire [3:0] highpass_corner_onehot_o, baseband_gain_onehot_o, nearfield_detect_level_o;
    wire [3:0] level_detector_upper_ref_o, level_detector_lower_ref_o;
    logic [31:0] q[$];
    logic [31:0] d;
    integer bad_count, num_checks, grants, seed, i;
    rfcs_regs dut (.*);
    rfcs_host_model host (.clk_sys_i(clk_sys_i), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
    initial
    begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input string n, input logic [31:0] e, g);
    begin
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    end
    endtask
    task end_sim;
    begin
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    task wt(input integer n);
    begin
        repeat (n) @(posedge clk_sys_i);
        #1;
    end
    endtask
    task rdc(input logic [15:0] a, input logic [31:0] e);
    begin
        q.push_back(e);
        host.rd(a);
    end
    endtask
    task fdc(input logic [31:0] v, input logic e);
    begin
        host.wr(16'h0023, v);
        wt(8);
        chk("field", e, field_present_o);
    end
    endtask
    task stby;
    begin
        @(posedge clk_sys_i) standby_req_i <= 1'b1;
        @(posedge clk_sys_i) standby_req_i <= 1'b0;
        wt(2);
    end
    endtask
    // ----
    // Read result watcher
    // ----
    always @(posedge clk_sys_i)
    begin
        rd_q <= rd_i;
        if (standby_grant_o === 1'b1)
            grants++;
        if (rd_q === 1'b1)
            chk("rdata", q.pop_front(), rdata_o);
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        bad_count++;
        end_sim;
    end
    initial
    begin
        {param_err_i, syntax_err_i, semantic_err_i, err_clear_i, standby_req_i} = 5'h00;
        {nearfield_det_i, level_det_i, overshoot_guard_i, card_mode_i} = 4'h0;
        {bad_count, num_checks, grants} = 0;
        seed = 80648;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        wt(1);
        chk("onehot", 8'h11, {highpass_corner_onehot_o, baseband_gain_onehot_o});
        for (i = 0; i < 5; i++)
            rdc(16'h0021 + i, 32'h0000_0000);
        $display("reset test done");
        // Bit 18 forced on so card load modulation is really exercised
        d = $random(seed) | 32'h0004_0000;
        host.wr(16'h0021, d);
        rdc(16'h0021, d & 32'h0004_3FFF);
        for (i = 0; i < 4; i++)
        begin
            @(posedge clk_sys_i) {overshoot_guard_i, card_mode_i} <= i[1:0];
            wt(3);
            chk("tx", {d[18] & i[0], i[0] ? d[4] : d[5], i[0] ? d[6] : d[7],
                i[1] ? d[10:8] : d[3:1], d[13:11], d[0]}, {card_load_mod_enable_o, driver1_invert_o,
                driver2_invert_o, tx_clock_mode_o, load_mod_clock_phase_o, digital_pll_enable_o});
        end
        $display("tx test done");
        for (i = 0; i < 4; i++)
        begin
            host.wr(16'h0022, 32'h0000_0055 * i);
            rdc(16'h0022, 32'h0000_0055 * i);
            wt(2);
            chk("rx", {i[1:0], i == 1, i == 2, 4'h1 << i, 4'h1 << i}, {miller_demod_reference_o,
                reader_mixer_en_o, card_mixer_en_o, highpass_corner_onehot_o, baseband_gain_onehot_o});
        end
        $display("rx test done");
        d = $random(seed);
        host.wr(16'h0023, d);
        rdc(16'h0023, d & 32'h0000_7FFF);
        wt(2);
        chk("fd", {d[14], d[11:0]}, {nearfield_detector_powerdown_o, nearfield_detect_level_o,
            level_detector_upper_ref_o, level_detector_lower_ref_o});
        @(posedge clk_sys_i) level_det_i <= 1'b1;
        for (i = 0; i < 4; i++)
            fdc(i << 12, i != 0);
        @(posedge clk_sys_i) {nearfield_det_i, level_det_i} <= 2'b10;
        fdc(32'h0000_4000, 1'b0);
        fdc(32'h0000_0000, 1'b1);
        $display("detector test done");
        @(posedge clk_sys_i) {param_err_i, syntax_err_i, semantic_err_i} <= 3'h7;
        @(posedge clk_sys_i) {param_err_i, syntax_err_i, semantic_err_i} <= 3'h0;
        stby;
        rdc(16'h0024, 32'h0000_01C0);
        @(posedge clk_sys_i) level_det_i <= 1'b1;
        wt(8);
        stby;
        host.wr(16'h0024, 32'hFFFF_FFFF);
        rdc(16'h0024, 32'h0000_01E0);
        // Clear meets a fresh parameter error in one cycle: the error stays
        @(posedge clk_sys_i) {err_clear_i, param_err_i} <= 2'b11;
        @(posedge clk_sys_i) {err_clear_i, param_err_i} <= 2'b00;
        rdc(16'h0024, 32'h0000_0120);
        // Mid-run reset must clear stored control and status words
        @(posedge clk_sys_i) rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rdc(16'h0021, 32'h0000_0000);
        rdc(16'h0024, 32'h0000_0000);
        wt(4);
        chk("grants", 1, grants);
        chk("queue", 0, q.size());
        $display("status test done");
        end_sim;
    end
endmodule // tb_top
bind rfcs_regs rfcs_chk chk_i (.*);
